// file: pac_lp_model.sv
`timescale 1ns/1ps
module pac_lp_model (
  input wire logic sys_clk, // Core clock
  input wire logic [2:0] lp_kind, // Bit0 10 link, bit1 100 link, bit2 negotiates
  input wire logic [15:0] lp_word, // Base page offered
  input wire logic flp_send, // Our bursts on the wire
  input wire logic tx_silence, // Our hold-off
  output logic link_10_good, // 10 Mb/s receiver link
  output logic link_100_good, // 100 Mb/s receiver link
  output logic flp_detected, // Partner bursts seen
  output pac_pkg::pac_page_t rx_page // Received page
);
  import pac_pkg::*;
  logic seen_q = 1'b0;
  logic [2:0] gap_q = 3'h0;
  // A negotiating partner only sends link once it has heard our bursts
  always_ff @(posedge sys_clk)
  begin
    seen_q <= !tx_silence && (seen_q || flp_send);
    link_10_good <= lp_kind[0] && (!lp_kind[2] || seen_q);
    link_100_good <= lp_kind[1] && (!lp_kind[2] || seen_q);
    flp_detected <= lp_kind[2];
  end
  // One page per eight cycles; word is scrambled between pages
  always_ff @(posedge sys_clk)
  begin
    gap_q <= gap_q + 3'h1;
    rx_page.valid <= lp_kind[2] && flp_send && gap_q == 3'h0;
    rx_page.word <= (gap_q == 3'h0) ? lp_word : ~lp_word;
    rx_page.next_page <= 1'b0;
  end
endmodule

// file: pac_pkg.sv
package pac_pkg;

  // ***************************************************************
  // Register indices (management register numbers)
  // ***************************************************************
  localparam logic [4:0] PAC_REG_BASIC_MODE_CONTROL = 5'h00;
  localparam logic [4:0] PAC_REG_BASIC_MODE_STATUS = 5'h01;
  localparam logic [4:0] PAC_REG_NEG_ADVERTISEMENT = 5'h04;
  localparam logic [4:0] PAC_REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] PAC_REG_NEG_EXPANSION = 5'h06;
  localparam logic [4:0] PAC_REG_PHY_LINK_STATUS = 5'h10;
  localparam logic [4:0] PAC_REG_PHY_CONTROL = 5'h19;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int PAC_BMC_SOFT_RESET = 15;
  localparam int PAC_BMC_SPEED = 13;
  localparam int PAC_BMC_NEG_EN = 12;
  localparam int PAC_BMC_ISOLATE = 10;
  localparam int PAC_BMC_RESTART = 9;
  localparam int PAC_BMC_DUPLEX = 8;
  localparam int PAC_ADV_10HD = 5;
  localparam int PAC_ADV_10FD = 6;
  localparam int PAC_ADV_100HD = 7;
  localparam int PAC_ADV_100FD = 8;
  localparam int PAC_PCR_AUTO_XOVER = 15;
  localparam int PAC_PCR_FORCE_XOVER = 14;

  // ***************************************************************
  // Constant values
  // ***************************************************************
  localparam logic [15:0] PAC_STATUS_FIXED = 16'h7849; // 100FD/HD,10FD/HD,suppr,neg able,ext; T4 clear
  localparam logic [15:0] PAC_STATUS_NEG_ABLE = 16'h0008;
  localparam logic [15:0] PAC_PD_100 = 16'h0081;
  localparam logic [15:0] PAC_PD_10 = 16'h0021;
  localparam logic [4:0] PAC_SELECTOR = 5'h01;
  localparam logic [4:0] PAC_ADDR_DEFAULT = 5'h01;
  localparam logic [15:0] PAC_ADV_BASE = 16'h0001;
  localparam int PAC_BREAK_LINK_MS = 1500;
  localparam int PAC_CLK_MHZ = 100;
  localparam longint PAC_BREAK_LINK_CYC = longint'(PAC_BREAK_LINK_MS) * 1000 * PAC_CLK_MHZ;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [4:0] {
    PAC_ST_FORCED = 5'b00001,
    PAC_ST_BREAK = 5'b00010,
    PAC_ST_ABILITY = 5'b00100,
    PAC_ST_LINK_CHECK = 5'b01000,
    PAC_ST_GOOD = 5'b10000
  } pac_state_t;

  // Partner page as delivered by the pulse receiver
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic next_page;
  } pac_page_t;

  // Resolved operating mode
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic link_up;
    logic complete;
  } pac_mode_t;

endpackage

// file: pac_top.sv
`timescale 1ns/1ps
module pac_top #(
  parameter longint BREAK_LINK_CYCLES = pac_pkg::PAC_BREAK_LINK_CYC // Hold-off length
) (
  input wire logic sys_clk, // Core clock 100 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic mdc, // Management clock, sampled
  input wire logic mdio_in, // Management data in
  output logic mdio_out, // Management data out
  output logic mdio_oe, // Management data drive enable
  input wire logic [4:0] strapped_mgmt_address, // Address straps
  input wire logic negotiation_enable_strap, // Negotiation enable strap
  input wire logic negotiation_mode_strap_high, // Mode strap high
  input wire logic negotiation_mode_strap_low, // Mode strap low
  input wire logic crossover_strap, // Automatic crossover strap
  input wire logic link_10_good, // 10 Mb/s receiver link
  input wire logic link_100_good, // 100 Mb/s receiver link
  input wire logic flp_detected, // Partner bursts being received
  input wire pac_pkg::pac_page_t rx_page, // Received code word
  input wire logic [3:0] txd, // MII transmit data
  input wire logic tx_en, // MII transmit enable
  output logic [3:0] txd_to_pcs, // Transmit data to coding
  output logic tx_en_to_pcs, // Transmit enable to coding
  output logic mii_out_oe, // MII outputs drive enable
  output logic flp_send, // Send bursts
  output logic [15:0] flp_word, // Word carried in bursts
  output logic tx_silence, // Halt data and link pulses
  output logic automatic_crossover, // Auto crossover active
  output logic force_crossover, // Crossover forced
  output pac_pkg::pac_mode_t mode // Operating mode
);
  import pac_pkg::*;

  // ***************************************************************
  // Strap capture
  // ***************************************************************
  logic boot_q;
  logic [15:0] bmc_q;
  logic [15:0] adv_q;
  logic [15:0] lpa_q;
  logic [15:0] pcr_q;
  logic isolate_strap_q;
  logic pd_fault_q;
  logic page_rx_q;
  logic partner_able_q;
  logic partner_np_q;
  logic rfault_q;
  logic [63:0] brk_cnt_q;
  pac_state_t state_q;
  logic restart_req;
  logic wr_stb;
  logic [4:0] wr_reg;
  logic [15:0] wr_data;
  logic [3:0] strap_ab;
  logic exp_rd_clr;

  initial
  begin
    if (BREAK_LINK_CYCLES < 1)
    begin
      $error("BREAK_LINK_CYCLES must be at least one");
    end
  end

  // Strap abilities: 100FD,100HD,10FD,10HD
  always_comb
  begin
    strap_ab = 4'h0;
    unique case ({negotiation_enable_strap, negotiation_mode_strap_high, negotiation_mode_strap_low})
      3'b000: strap_ab = 4'b0001;
      3'b001: strap_ab = 4'b0010;
      3'b010: strap_ab = 4'b0100;
      3'b011: strap_ab = 4'b1000;
      3'b100: strap_ab = 4'b0011;
      3'b101: strap_ab = 4'b1100;
      3'b110: strap_ab = 4'b0101;
      3'b111: strap_ab = 4'b1111;
    endcase
  end

  // Straps are sampled one edge after reset release, never under reset
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      boot_q <= 1'b1;
    else
      boot_q <= 1'b0;
  end

  // ***************************************************************
  // Control registers
  // ***************************************************************
  // Basic control; restart bit self-clears once accepted
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      bmc_q <= 16'h0000;
    else if (boot_q)
    begin
      bmc_q <= 16'h0000;
      bmc_q[PAC_BMC_NEG_EN] <= negotiation_enable_strap;
      bmc_q[PAC_BMC_SPEED] <= negotiation_mode_strap_high;
      bmc_q[PAC_BMC_DUPLEX] <= negotiation_mode_strap_low;
    end
    else if (wr_stb && wr_reg == PAC_REG_BASIC_MODE_CONTROL)
    begin
      bmc_q <= wr_data;
      bmc_q[PAC_BMC_SOFT_RESET] <= 1'b0;
    end
    else if (state_q == PAC_ST_BREAK)
      bmc_q[PAC_BMC_RESTART] <= 1'b0;
  end

  // Advertisement; strap chooses bits 8:5, writes may restrict
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      adv_q <= PAC_ADV_BASE;
    else if (boot_q)
      adv_q <= {7'h00, strap_ab, PAC_SELECTOR};
    else if (wr_stb && wr_reg == PAC_REG_NEG_ADVERTISEMENT)
      adv_q <= wr_data;
  end

  // Phy control: crossover bits writable, address latched from straps only
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pcr_q <= {1'b1, 10'h000, PAC_ADDR_DEFAULT};
      isolate_strap_q <= 1'b0;
    end
    else if (boot_q)
    begin
      pcr_q <= {crossover_strap, 10'h000, strapped_mgmt_address};
      isolate_strap_q <= (strapped_mgmt_address == 5'h00);
    end
    else if (wr_stb && wr_reg == PAC_REG_PHY_CONTROL)
      pcr_q[15:5] <= wr_data[15:5];
  end

  // ***************************************************************
  // Negotiation sequence
  // ***************************************************************
  logic neg_en;
  logic neg_en_d1_q;
  logic armed_q;
  logic one_link;
  logic pd_complete_q;
  assign neg_en = bmc_q[PAC_BMC_NEG_EN];
  assign one_link = link_10_good ^ link_100_good;
  // Restart on bit 9 write, or on an enable rising edge
  assign restart_req = (wr_stb && wr_reg == PAC_REG_BASIC_MODE_CONTROL && wr_data[PAC_BMC_RESTART])
                       || (neg_en && !neg_en_d1_q);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      neg_en_d1_q <= 1'b0;
    else
      neg_en_d1_q <= neg_en;
  end

  // Main sequence: hold-off, ability exchange, link check, good
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || boot_q)
      state_q <= PAC_ST_FORCED;
    else if (!neg_en)
      state_q <= PAC_ST_FORCED;
    else if (restart_req)
      state_q <= PAC_ST_BREAK;
    else
    begin
      unique case (state_q)
        PAC_ST_FORCED: state_q <= PAC_ST_FORCED;
        PAC_ST_BREAK: if (brk_cnt_q >= 64'(BREAK_LINK_CYCLES - 1)) state_q <= PAC_ST_ABILITY;
        PAC_ST_ABILITY: if ((rx_page.valid && !rx_page.next_page) || (!flp_detected && one_link))
          state_q <= PAC_ST_LINK_CHECK;
        PAC_ST_LINK_CHECK: if (link_10_good || link_100_good) state_q <= PAC_ST_GOOD;
        PAC_ST_GOOD: if (!(link_10_good || link_100_good)) state_q <= PAC_ST_BREAK;
      endcase
    end
  end

  // Hold-off counter on the core clock
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || state_q != PAC_ST_BREAK || restart_req)
      brk_cnt_q <= 64'h0;
    else
      brk_cnt_q <= brk_cnt_q + 64'h1;
  end

  // Partner register and expansion status; page events win over parallel detection and the read clear
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || boot_q)
    begin
      lpa_q <= 16'h0000;
      partner_able_q <= 1'b0;
      partner_np_q <= 1'b0;
      page_rx_q <= 1'b0;
      pd_complete_q <= 1'b0;
      pd_fault_q <= 1'b0;
      armed_q <= 1'b0;
      rfault_q <= 1'b0;
    end
    else
    begin
      armed_q <= 1'b0;
      if (state_q == PAC_ST_BREAK)
      begin
        lpa_q <= 16'h0000;
        partner_able_q <= 1'b0;
        pd_complete_q <= 1'b0;
      end
      if (state_q == PAC_ST_ABILITY && rx_page.valid)
      begin
        lpa_q <= rx_page.word;
        partner_able_q <= 1'b1;
        partner_np_q <= rx_page.word[15];
        rfault_q <= rx_page.word[13];
        page_rx_q <= 1'b1;
      end
      else if (state_q == PAC_ST_ABILITY && !flp_detected && one_link)
      begin
        lpa_q <= link_100_good ? PAC_PD_100 : PAC_PD_10;
        partner_able_q <= 1'b0;
        pd_complete_q <= 1'b1;
      end
      else if (exp_rd_clr)
        page_rx_q <= 1'b0;
      // Fault is sticky until read; set wins over the read clear
      if (state_q == PAC_ST_ABILITY && !flp_detected && link_10_good && link_100_good)
        pd_fault_q <= 1'b1;
      else if (exp_rd_clr)
        pd_fault_q <= 1'b0;
    end
  end

  // Resolution of operating mode
  logic [3:0] common;
  always_comb
  begin
    common = {adv_q[PAC_ADV_100FD], adv_q[PAC_ADV_100HD], adv_q[PAC_ADV_10FD], adv_q[PAC_ADV_10HD]}
             & {lpa_q[PAC_ADV_100FD], lpa_q[PAC_ADV_100HD], lpa_q[PAC_ADV_10FD], lpa_q[PAC_ADV_10HD]};
    mode.link_up = link_10_good || link_100_good;
    mode.complete = (state_q == PAC_ST_GOOD);
    if (!neg_en)
    begin
      mode.speed_100 = bmc_q[PAC_BMC_SPEED];
      mode.full_duplex = bmc_q[PAC_BMC_DUPLEX];
    end
    else if (common[3])
    begin
      mode.speed_100 = 1'b1;
      mode.full_duplex = 1'b1;
    end
    else if (common[2])
    begin
      mode.speed_100 = 1'b1;
      mode.full_duplex = 1'b0;
    end
    else
    begin
      mode.speed_100 = 1'b0;
      mode.full_duplex = common[1];
    end
  end

  // ***************************************************************
  // Media and MII side
  // ***************************************************************
  logic isolate;
  assign isolate = bmc_q[PAC_BMC_ISOLATE] || isolate_strap_q;
  assign tx_silence = (state_q == PAC_ST_BREAK);
  assign flp_send = (state_q == PAC_ST_ABILITY) || (state_q == PAC_ST_LINK_CHECK);
  assign flp_word = adv_q;
  assign mii_out_oe = !isolate;
  assign automatic_crossover = pcr_q[PAC_PCR_AUTO_XOVER] && neg_en;
  assign force_crossover = pcr_q[PAC_PCR_FORCE_XOVER];

  // Transmit data is blocked in isolate and hold-off
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || isolate || tx_silence)
    begin
      txd_to_pcs <= 4'h0;
      tx_en_to_pcs <= 1'b0;
    end
    else
    begin
      txd_to_pcs <= txd;
      tx_en_to_pcs <= tx_en;
    end
  end

  // ***************************************************************
  // Management frame engine
  // ***************************************************************
  // Frames are decoded on rising mdc; answers run regardless of isolate
  logic mdc_q;
  logic mdc_rise;
  logic [5:0] bit_cnt_q;
  logic [31:0] sh_q;
  logic [15:0] rd_sh_q;
  logic [15:0] rd_val;
  logic rd_stb;
  logic [4:0] rd_reg;
  logic reading_q;
  logic [4:0] reg_q;
  assign mdc_rise = mdc && !mdc_q;

  always_comb
  begin
    rd_val = 16'h0000;
    unique case (reg_q)
      PAC_REG_BASIC_MODE_CONTROL: rd_val = bmc_q;
      PAC_REG_BASIC_MODE_STATUS: rd_val = PAC_STATUS_FIXED
        | {10'h000, (state_q == PAC_ST_GOOD), rfault_q, 1'b0, mode.link_up, 2'b00};
      PAC_REG_NEG_ADVERTISEMENT: rd_val = adv_q;
      PAC_REG_PARTNER_ABILITY: rd_val = lpa_q;
      PAC_REG_NEG_EXPANSION: rd_val = {11'h000, pd_fault_q, partner_np_q, 1'b0, page_rx_q, partner_able_q};
      PAC_REG_PHY_LINK_STATUS: rd_val = {11'h000, pd_complete_q, mode.complete, 1'b0,
                                         mode.full_duplex, !mode.speed_100 || !mode.link_up};
      PAC_REG_PHY_CONTROL: rd_val = pcr_q;
      default: rd_val = 16'h0000;
    endcase
  end

  assign wr_stb = mdc_rise && !reading_q && bit_cnt_q == 6'd31 && sh_q[30:29] == 2'b01
                  && sh_q[28:27] == 2'b01 && sh_q[26:22] == pcr_q[4:0];
  assign wr_reg = sh_q[21:17];
  assign wr_data = {sh_q[14:0], mdio_in};
  assign rd_stb = mdc_rise && bit_cnt_q == 6'd13 && sh_q[12:11] == 2'b01 && sh_q[10:9] == 2'b10
                  && sh_q[8:4] == pcr_q[4:0];
  assign rd_reg = {sh_q[3:0], mdio_in};
  // Expansion flags clear only once their value sits in the shift register, so a read never loses them
  assign exp_rd_clr = mdc_rise && reading_q && bit_cnt_q == 6'd14 && reg_q == PAC_REG_NEG_EXPANSION;

  // Bit counter waits for preamble-free start 01; preamble is optional
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mdc_q <= 1'b0;
      bit_cnt_q <= 6'h00;
      sh_q <= 32'hffffffff;
      reading_q <= 1'b0;
      reg_q <= 5'h00;
      rd_sh_q <= 16'h0;
      mdio_oe <= 1'b0;
      mdio_out <= 1'b0;
    end
    else
    begin
      mdc_q <= mdc;
      if (mdc_rise)
      begin
        sh_q <= {sh_q[30:0], mdio_in};
        if (bit_cnt_q == 6'h00)
          bit_cnt_q <= (sh_q[0] == 1'b0 && mdio_in) ? 6'd2 : 6'd0;
        else if (bit_cnt_q == 6'd31)
        begin
          bit_cnt_q <= 6'h00;
          sh_q[0] <= 1'b1; // Line counts as idle, so a trailing zero is no start bit
          reading_q <= 1'b0;
          mdio_oe <= 1'b0;
        end
        else
          bit_cnt_q <= bit_cnt_q + 6'd1;
        if (rd_stb)
        begin
          reading_q <= 1'b1;
          reg_q <= rd_reg;
        end
        // Each answer bit is driven one mdc rise ahead of the rise at which the master samples it
        if (reading_q && bit_cnt_q == 6'd14)
        begin
          mdio_oe <= 1'b1;
          mdio_out <= 1'b0;
          rd_sh_q <= rd_val;
        end
        else if (reading_q && bit_cnt_q > 6'd14 && bit_cnt_q < 6'd31)
        begin
          mdio_out <= rd_sh_q[15];
          rd_sh_q <= {rd_sh_q[14:0], 1'b0};
        end
      end
    end
  end

endmodule

// file: pac_top_props.sv
`timescale 1ns/1ps
module pac_top_props #(
  parameter longint BREAK_LINK_CYCLES = 16 // Hold-off length
) (
  input wire logic sys_clk, // Core clock
  input wire logic reset_n, // Sync reset
  input wire logic mdio_out, // Management data out
  input wire logic mdio_oe, // Management drive enable
  input wire logic tx_en, // MII transmit enable
  input wire logic [3:0] txd_to_pcs, // Data to coding
  input wire logic tx_en_to_pcs, // Enable to coding
  input wire logic mii_out_oe, // MII drive enable
  input wire logic flp_send, // Bursts active
  input wire logic tx_silence, // Hold-off active
  input wire logic automatic_crossover, // Auto crossover
  input wire pac_pkg::pac_mode_t mode // Operating mode
);
  import pac_pkg::*;
  // ***************************************************************
  // Hold-off, transmit gating and read answer
  // ***************************************************************
  logic [31:0] sil_cnt_q;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // Length of the running hold-off; cleared as soon as it ends
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || !tx_silence)
      sil_cnt_q <= 32'h0;
    else
      sil_cnt_q <= sil_cnt_q + 32'h1;
  end
  // A hold-off that ends while negotiation is still on
  sequence s_break_over;
    $fell(tx_silence) ##0 automatic_crossover;
  endsequence
  property p_hold_len;
    $fell(tx_silence) |-> sil_cnt_q + 1 >= BREAK_LINK_CYCLES && sil_cnt_q <= BREAK_LINK_CYCLES + 1;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold-off length wrong");
  property p_burst_resume;
    s_break_over |-> ##[0:2] flp_send;
  endproperty
  a_burst_resume: assert property (p_burst_resume) else $error("no bursts after hold-off");
  property p_quiet_bursts;
    tx_silence |-> !flp_send;
  endproperty
  a_quiet_bursts: assert property (p_quiet_bursts) else $error("bursts during hold-off");
  property p_quiet_data;
    tx_silence && $past(tx_silence) |-> !tx_en_to_pcs && txd_to_pcs == 4'h0;
  endproperty
  a_quiet_data: assert property (p_quiet_data) else $error("data during hold-off");
  property p_iso_data;
    !mii_out_oe && $past(!mii_out_oe) |-> !tx_en_to_pcs;
  endproperty
  a_iso_data: assert property (p_iso_data) else $error("transmit passed in isolate");
  property p_tx_copy;
    mii_out_oe && !tx_silence && $past(mii_out_oe && !tx_silence) |-> tx_en_to_pcs == $past(tx_en);
  endproperty
  a_tx_copy: assert property (p_tx_copy) else $error("transmit enable not passed");
  property p_loss_restart;
    $fell(mode.complete) && automatic_crossover |-> ##[0:2] tx_silence;
  endproperty
  a_loss_restart: assert property (p_loss_restart) else $error("no restart after link loss");
  property p_ta_low;
    $rose(mdio_oe) |-> !mdio_out ##1 mdio_oe [*8];
  endproperty
  a_ta_low: assert property (p_ta_low) else $error("read answer malformed");
endmodule
bind pac_top pac_top_props #(.BREAK_LINK_CYCLES(BREAK_LINK_CYCLES)) chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .tx_en(tx_en),
  .txd_to_pcs(txd_to_pcs), .tx_en_to_pcs(tx_en_to_pcs), .mii_out_oe(mii_out_oe), .flp_send(flp_send),
  .tx_silence(tx_silence), .automatic_crossover(automatic_crossover), .mode(mode));

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import pac_pkg::*;
  logic sys_clk = 0, reset_n = 0, mdc = 0, tb_oe = 0, tb_do = 1, mdio_in, mdio_out, mdio_oe;
  logic [4:0] strap_addr = 5'h01, phy_addr = 5'h01;
  logic [3:0] txd = 4'h0, txd_to_pcs;
  logic tx_en = 0, tx_en_to_pcs, mii_out_oe, flp_send, tx_silence, auto_x, force_x;
  logic link_10_good, link_100_good, flp_detected;
  logic [2:0] lp_kind = 3'h0;
  logic [2:0] neg_strap = 3'h7;
  logic [15:0] lp_word = 16'h0, flp_word, rv;
  pac_page_t rx_page;
  pac_mode_t mode;
  int err_total = 0, samples_checked = 0;
  // Open-drain style wire with pull-up when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (tb_oe ? tb_do : 1'b1);
  pac_top #(.BREAK_LINK_CYCLES(16)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .strapped_mgmt_address(strap_addr),
    .negotiation_enable_strap(neg_strap[2]), .negotiation_mode_strap_high(neg_strap[1]),
    .negotiation_mode_strap_low(neg_strap[0]),
    .crossover_strap(1'b1), .link_10_good(link_10_good), .link_100_good(link_100_good),
    .flp_detected(flp_detected), .rx_page(rx_page), .txd(txd), .tx_en(tx_en), .txd_to_pcs(txd_to_pcs),
    .tx_en_to_pcs(tx_en_to_pcs), .mii_out_oe(mii_out_oe), .flp_send(flp_send), .flp_word(flp_word),
    .tx_silence(tx_silence), .automatic_crossover(auto_x), .force_crossover(force_x), .mode(mode));
  pac_lp_model lp_u (.sys_clk(sys_clk), .lp_kind(lp_kind), .lp_word(lp_word), .flp_send(flp_send),
    .tx_silence(tx_silence), .link_10_good(link_10_good), .link_100_good(link_100_good),
    .flp_detected(flp_detected), .rx_page(rx_page));
  // 100 MHz core clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Whole frame with preamble; mdc period is ten core cycles, six high and four low
  task automatic frame(input logic rd, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rq);
    logic [63:0] bits;
    bits = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, phy_addr, ra, 2'b10, wd};
    rq = 16'h0;
    for (int i = 63; i >= 0; i--)
    begin
      @(negedge sys_clk);
      mdc = 1'b0;
      tb_oe = !(rd && i < 18);
      tb_do = bits[i];
      repeat (4) @(negedge sys_clk);
      if (rd && i < 16)
        rq[i] = mdio_out;
      mdc = 1'b1;
      repeat (5) @(negedge sys_clk);
    end
    mdc = 1'b0;
    tb_oe = 1'b0;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    frame(1'b0, ra, wd, d);
  endtask
  task automatic rd(input logic [4:0] ra);
    frame(1'b1, ra, 16'h0, rv);
  endtask
  // Bounded wait: 0 bursts, 1 complete, 2 hold-off
  task automatic await(input int which);
    int n;
    n = 0;
    while (n < 300 && !(which == 0 ? flp_send === 1'b1 : which == 1 ? mode.complete === 1'b1 : tx_silence === 1'b1))
    begin
      @(negedge sys_clk);
      n++;
    end
    check("wait", 16'(which), n < 300 ? 16'(which) : 16'hffff);
  endtask
  task automatic do_reset(input logic [4:0] addr);
    reset_n = 1'b0;
    strap_addr = addr;
    phy_addr = addr;
    repeat (10) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic renegotiate(input logic [2:0] kind, input logic [15:0] w);
    lp_kind = kind;
    lp_word = w;
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h1200);
    await(1);
  endtask
  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_defaults;
    rd(PAC_REG_BASIC_MODE_STATUS);
    check("status", rv, PAC_STATUS_FIXED);
    rd(PAC_REG_NEG_ADVERTISEMENT);
    check("advert", rv, 16'h01e1);
    rd(PAC_REG_PHY_CONTROL);
    check("phyctl", rv, 16'h8001);
    rd(5'h02);
    check("unmapped", rv, 16'h0000);
    wr(PAC_REG_PHY_CONTROL, 16'h4000);
    check("xover", {14'h0, auto_x, force_x}, 16'h0001);
    check("no isolate", {15'h0, mii_out_oe}, 16'h0001);
    wr(PAC_REG_PHY_CONTROL, 16'h8000);
  endtask
  // Every priority outcome, then a suppressed ability, then link loss
  task automatic t_negotiate;
    logic [15:0] pw [4] = '{16'h01e1, 16'h00e1, 16'h0061, 16'h0021};
    logic [2:0] kd [4] = '{3'b110, 3'b110, 3'b101, 3'b101};
    for (int i = 0; i < 4; i++)
    begin
      renegotiate(kd[i], pw[i]);
      check("mode", {12'h0, mode}, {12'h0, 2'(3 - i), 2'b11});
    end
    wr(PAC_REG_NEG_ADVERTISEMENT, 16'h00e1);
    lp_kind = 3'b110;
    lp_word = 16'h01e1;
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h1200);
    await(0);
    check("burst word", flp_word, 16'h00e1);
    await(1);
    check("mode", {12'h0, mode}, 16'h000b);
    rd(PAC_REG_PARTNER_ABILITY);
    check("partner", rv, 16'h01e1);
    rd(PAC_REG_NEG_EXPANSION);
    check("expansion", rv & 16'h001b, 16'h0003);
    rd(PAC_REG_BASIC_MODE_STATUS);
    check("status", rv, PAC_STATUS_FIXED | 16'h0024);
    lp_kind = 3'b000;
    await(2);
  endtask
  task automatic t_parallel;
    renegotiate(3'b001, 16'h0);
    check("pd mode", {12'h0, mode}, 16'h0003);
    rd(PAC_REG_PARTNER_ABILITY);
    check("pd 10", rv, PAC_PD_10);
    rd(PAC_REG_NEG_EXPANSION);
    check("pd able", rv & 16'h0001, 16'h0000);
    check("pd complete", {15'h0, mode.complete}, 16'h0001);
    renegotiate(3'b010, 16'h0);
    rd(PAC_REG_PARTNER_ABILITY);
    check("pd 100", rv, PAC_PD_100);
    rd(PAC_REG_PHY_LINK_STATUS);
    check("link status", rv, 16'h0018);
    lp_kind = 3'b011;
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h1200);
    await(0);
    rd(PAC_REG_NEG_EXPANSION);
    check("pd fault", rv & 16'h0010, 16'h0010);
  endtask
  task automatic t_forced;
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h2100);
    check("forced 100 full", {14'h0, mode.speed_100, mode.full_duplex}, 16'h0003);
    check("no auto xover", {15'h0, auto_x}, 16'h0000);
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h0000);
    check("forced 10 half", {14'h0, mode.speed_100, mode.full_duplex}, 16'h0000);
    lp_kind = 3'b010;
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h1000);
    await(2);
    await(1);
  endtask
  task automatic t_isolate;
    tx_en = 1'b1;
    txd = 4'ha;
    repeat (3) @(negedge sys_clk);
    check("tx pass", {11'h0, tx_en_to_pcs, txd_to_pcs}, 16'h001a);
    wr(PAC_REG_BASIC_MODE_CONTROL, 16'h1400);
    check("tx blocked", {10'h0, mii_out_oe, tx_en_to_pcs, txd_to_pcs}, 16'h0000);
    rd(PAC_REG_BASIC_MODE_STATUS);
    check("iso status", rv, PAC_STATUS_FIXED | 16'h0024);
    tx_en = 1'b0;
    neg_strap = 3'b011;
    do_reset(5'h00);
    check("strap isolate", {15'h0, mii_out_oe}, 16'h0000);
    rd(PAC_REG_PHY_CONTROL);
    check("addr zero", rv, 16'h8000);
    rd(PAC_REG_NEG_ADVERTISEMENT);
    check("strap advert", rv, 16'h0101);
    check("strap forced", {13'h0, auto_x, mode.speed_100, mode.full_duplex}, 16'h0003);
  endtask
  // Main sequence
  initial
  begin
    do_reset(5'h01);
    t_defaults();
    t_negotiate();
    t_parallel();
    t_forced();
    t_isolate();
    final_report();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    final_report();
  end
endmodule
